/* File: verilog/pwr_ctrl_pkg.sv */
// Constants for the power-mode control block: register map, field layout, reset values.
// Assumes a single 40 MHz system clock and a synchronous active-high reset.
package pwr_ctrl_pkg;
	localparam logic [7:0]  OFS_CTRL1 = 8'h00;
	localparam logic [7:0]  OFS_CTRL2 = 8'h04;
	localparam logic [7:0]  OFS_CTRL3 = 8'h08;
	localparam logic [7:0]  OFS_STS1  = 8'h0c;
	localparam logic [7:0]  OFS_STS2  = 8'h10;
	localparam logic [7:0]  OFS_CLR   = 8'h14;
	localparam logic [7:0]  OFS_IMASK = 8'h18;
	localparam logic [7:0]  OFS_ISTAT = 8'h1c;
	localparam logic [7:0]  OFS_RTCS  = 8'h20;
	localparam logic [31:0] CTRL1_RST = 32'h0000_0700;
	localparam logic [31:0] CTRL1_WM  = 32'h0000_4707;
	localparam logic [31:0] CTRL2_RST = 32'h0000_0000;
	localparam logic [31:0] CTRL2_WM  = 32'h0000_001f;
	localparam logic [31:0] CTRL3_RST = 32'h0007_0700;
	localparam logic [31:0] CTRL3_WM  = 32'h0037_7777;
	localparam int          LPRUN_EN_BIT = 14;
	localparam int          MRL_HI    = 10;
	localparam int          MRL_LO    = 9;
	localparam int          UNLK_BIT  = 8;
	localparam int          IWK_BIT   = 14;
	localparam int          STBY_FLAG_BIT = 8;
	localparam int          IWKF_BIT  = 15;
	localparam logic [2:0]  SEL_STBY  = 3'h3;
	localparam logic [1:0]  MRL_1V0   = 2'h2;
	localparam logic [1:0]  MRL_1V1   = 2'h3;
	localparam logic [1:0]  BRESP_OK  = 2'h0;
	localparam logic [1:0]  BRESP_ERR = 2'h2;
	// Interrupt event bits: 0 standby exit, 1 any stop2 or standby wake, 2 regulator switch done.
	localparam int          NEV       = 3;
	localparam logic [2:0]  IMASK_RST = 3'h0;
	typedef enum logic [1:0] {
		PM_RUN   = 2'b00,
		PM_STOP2 = 2'b01,
		PM_STBY  = 2'b10
	} pmode_t;
endpackage : pwr_ctrl_pkg

/* File: verilog/wake_router.sv */
// Wake routing: turns an alarm into a wake request for the current deep-sleep state.
// Assumes alarm and line-18 inputs are synchronous single-cycle or level events.
`timescale 1ns/1ps
module wake_router
	import pwr_ctrl_pkg::*;
(
	input  wire logic   clk_in,
	input  wire logic   srst_in,
	input  wire pmode_t mode_in,
	input  wire logic   sleep_in,
	input  wire logic   alarm_in,
	input  wire logic   line18_in,
	input  wire logic   iwk_en_in,
	output logic        wake_out,
	output logic        stby_alarm_out
);
	logic alarm_d;
	logic next_alarm_d;

	always_comb begin
		next_alarm_d = alarm_in;
		// Sleep wakes on any alarm; stop2 needs the interrupt line; standby the internal line.
		wake_out = 1'b0;
		stby_alarm_out = 1'b0;
		case (mode_in)
			PM_RUN:   wake_out = sleep_in & alarm_in & ~alarm_d;
			PM_STOP2: wake_out = line18_in;
			PM_STBY: begin
				stby_alarm_out = iwk_en_in & alarm_in & ~alarm_d;
				wake_out = stby_alarm_out;
			end
			default:  wake_out = 1'b0;
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			alarm_d <= 1'b0;
		end else begin
			alarm_d <= next_alarm_d;
		end
	end
endmodule : wake_router

/* File: verilog/power_mode_control_autowake.sv */
// Power-mode control top: AXI4-Lite register slave, regulator and deep-sleep steering, wake logic.
// Assumes one 40 MHz clock; the real-time clock and interrupt lines live outside and arrive synchronous.
`timescale 1ns/1ps
module power_mode_control_autowake
	import pwr_ctrl_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        srst_in,
	input  wire logic [7:0]  s_axi_awaddr_in,
	input  wire logic        s_axi_awvalid_in,
	output logic             s_axi_awready_out,
	input  wire logic [31:0] s_axi_wdata_in,
	input  wire logic [3:0]  s_axi_wstrb_in,
	input  wire logic        s_axi_wvalid_in,
	output logic             s_axi_wready_out,
	output logic [1:0]       s_axi_bresp_out,
	output logic             s_axi_bvalid_out,
	input  wire logic        s_axi_bready_in,
	input  wire logic [7:0]  s_axi_araddr_in,
	input  wire logic        s_axi_arvalid_in,
	output logic             s_axi_arready_out,
	output logic [31:0]      s_axi_rdata_out,
	output logic [1:0]       s_axi_rresp_out,
	output logic             s_axi_rvalid_out,
	input  wire logic        s_axi_rready_in,
	input  wire logic        deep_sleep_req_in,
	input  wire logic        sleep_req_in,
	input  wire logic        rtc_alarm_in,
	input  wire logic        line18_wake_in,
	input  wire logic        pvd_out_in,
	output logic             main_regulator_on_out,
	output logic             low_power_regulator_on_out,
	output logic [1:0]       main_regulator_level_out,
	output logic             level_1v0_out,
	output logic             level_1v1_out,
	output logic             backup_write_enable_out,
	output logic [1:0]       rtc_source_select_out,
	output logic             stop2_out,
	output logic             standby_out,
	output logic             irq_out
);
	logic [31:0]    ctrl1;
	logic [31:0]    ctrl2;
	logic [31:0]    ctrl3;
	logic [31:0]    next_ctrl1;
	logic [31:0]    next_ctrl2;
	logic [31:0]    next_ctrl3;
	logic           stby_flag;
	logic           iwkf;
	logic           next_stby_flag;
	logic           next_iwkf;
	logic [NEV-1:0] istat;
	logic [NEV-1:0] imask;
	logic [NEV-1:0] next_istat;
	logic [NEV-1:0] next_imask;
	logic [1:0]     rtc_src;
	logic [1:0]     next_rtc_src;
	pmode_t         mode;
	pmode_t         next_mode;
	logic           aw_h;
	logic           w_h;
	logic           next_aw_h;
	logic           next_w_h;
	logic [7:0]     awa;
	logic [7:0]     next_awa;
	logic [31:0]    wd;
	logic [31:0]    next_wd;
	logic [3:0]     ws;
	logic [3:0]     next_ws;
	logic           bv;
	logic           next_bv;
	logic           rv;
	logic           next_rv;
	logic [1:0]     br;
	logic [1:0]     next_br;
	logic [31:0]    rd;
	logic [31:0]    next_rd;
	logic [31:0]    rmux;
	logic           lp_run_d;
	logic           next_lp_run_d;
	logic           wake;
	logic           stby_alarm;
	logic           do_wr;
	logic           do_rd;
	logic [31:0]    wmask;
	logic [31:0]    sts1;
	logic [31:0]    sts2;

	// The router keeps the alarm edge detector, so a held alarm wakes the block only once.
	wake_router u_wake (
		.clk_in         (clk_in),
		.srst_in        (srst_in),
		.mode_in        (mode),
		.sleep_in       (sleep_req_in),
		.alarm_in       (rtc_alarm_in),
		.line18_in      (line18_wake_in),
		.iwk_en_in      (ctrl3[IWK_BIT]),
		.wake_out       (wake),
		.stby_alarm_out (stby_alarm)
	);

	// Byte strobes widen to a bit mask so each lane of a write lands on its own.
	for (genvar i = 0; i < 4; i++) begin : g_strb
		assign wmask[8*i +: 8] = {8{ws[i]}};
	end

	// A write executes only when both halves are held and no earlier answer is still pending.
	assign do_wr = aw_h & w_h & ~bv;
	assign do_rd = s_axi_arvalid_in & ~rv;
	// Each write channel closes once its half is held, and both stay closed while the answer waits.
	assign s_axi_awready_out = ~aw_h & ~bv;
	assign s_axi_wready_out  = ~w_h & ~bv;
	assign s_axi_arready_out = ~rv;
	assign s_axi_bvalid_out  = bv;
	assign s_axi_bresp_out   = br;
	assign s_axi_rvalid_out  = rv;
	assign s_axi_rresp_out   = BRESP_OK;
	assign s_axi_rdata_out   = rd;

	assign sts1 = {16'h0, iwkf, 6'h0, stby_flag, 8'h0};
	// Status two: low-power-run state one cycle late, main regulator on, voltage detector.
	assign sts2 = {29'h0, pvd_out_in, ~ctrl1[LPRUN_EN_BIT], lp_run_d};

	// Reserved bits and the write-only clear register read as zero.
	always_comb begin
		case (s_axi_araddr_in)
			OFS_CTRL1: rmux = ctrl1;
			OFS_CTRL2: rmux = ctrl2;
			OFS_CTRL3: rmux = ctrl3;
			OFS_STS1:  rmux = sts1;
			OFS_STS2:  rmux = sts2;
			OFS_CLR:   rmux = 32'h0;
			OFS_IMASK: rmux = {29'h0, imask};
			OFS_ISTAT: rmux = {29'h0, istat};
			OFS_RTCS:  rmux = {30'h0, rtc_src};
			default: begin
				// Unmapped offsets read as zero with an OKAY answer, so a probe never stalls.
				rmux = 32'h0;
			end
		endcase
	end

	always_comb begin
		next_aw_h = aw_h;
		next_w_h  = w_h;
		next_awa  = awa;
		next_wd   = wd;
		next_ws   = ws;
		next_bv   = bv;
		next_br   = br;
		next_rv   = rv;
		next_rd   = rd;
		next_ctrl1 = ctrl1;
		next_ctrl2 = ctrl2;
		next_ctrl3 = ctrl3;
		next_stby_flag = stby_flag;
		next_iwkf  = iwkf;
		next_imask = imask;
		next_rtc_src = rtc_src;
		next_istat = istat;
		next_mode  = mode;
		next_lp_run_d = ctrl1[LPRUN_EN_BIT];
		if (s_axi_awvalid_in && s_axi_awready_out) begin
			next_aw_h = 1'b1;
			next_awa  = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && s_axi_wready_out) begin
			next_w_h = 1'b1;
			next_wd  = s_axi_wdata_in;
			next_ws  = s_axi_wstrb_in;
		end
		if (bv && s_axi_bready_in) begin
			next_bv = 1'b0;
		end
		if (rv && s_axi_rready_in) begin
			next_rv = 1'b0;
		end
		if (do_wr) begin
			next_aw_h = 1'b0;
			next_w_h  = 1'b0;
			next_bv   = 1'b1;
			next_br   = BRESP_OK;
			case (awa)
				OFS_CTRL1: next_ctrl1 = (ctrl1 & ~(wmask & CTRL1_WM)) | (wd & wmask & CTRL1_WM);
				OFS_CTRL2: next_ctrl2 = (ctrl2 & ~(wmask & CTRL2_WM)) | (wd & wmask & CTRL2_WM);
				OFS_CTRL3: next_ctrl3 = (ctrl3 & ~(wmask & CTRL3_WM)) | (wd & wmask & CTRL3_WM);
				OFS_STS1, OFS_STS2: next_br = BRESP_OK;
				OFS_CLR: begin
					if (ws[1] && wd[STBY_FLAG_BIT]) begin
						next_stby_flag = 1'b0;
					end
					if (ws[1] && wd[IWKF_BIT]) begin
						next_iwkf = 1'b0;
					end
				end
				OFS_IMASK: if (ws[0]) next_imask = wd[NEV-1:0];
				// The clock source lives in the backup domain, so it obeys the unlock bit.
				OFS_RTCS: if (ws[0] && ctrl1[UNLK_BIT]) next_rtc_src = wd[1:0];
				default: next_br = BRESP_ERR;
			endcase
		end
		if (do_rd) begin
			next_rv = 1'b1;
			next_rd = rmux;
			// Reading the event register clears it; a fresh event below still wins.
			if (s_axi_araddr_in == OFS_ISTAT) begin
				next_istat = '0;
			end
		end
		// An unused deep-sleep code leaves the block running rather than guessing a target.
		case (mode)
			PM_RUN: begin
				if (deep_sleep_req_in) begin
					next_mode = (ctrl1[2:0] == SEL_STBY) ? PM_STBY :
						(ctrl1[2:0] < SEL_STBY) ? PM_STOP2 : PM_RUN;
				end
			end
			PM_STOP2: if (wake) next_mode = PM_RUN;
			PM_STBY: begin
				if (wake) begin
					next_mode  = PM_RUN;
					// Standby exit resets the control registers but keeps the status flags.
					next_ctrl1 = CTRL1_RST;
					next_ctrl2 = CTRL2_RST;
					next_ctrl3 = CTRL3_RST;
					next_rtc_src = 2'h0;
					next_imask = IMASK_RST;
				end
			end
			default: next_mode = PM_RUN;
		endcase
		if (mode == PM_STBY && wake) begin
			next_stby_flag = 1'b1;
			next_istat[0] = 1'b1;
		end
		if (stby_alarm) begin
			next_iwkf = 1'b1;
		end
		if (wake && mode != PM_RUN) begin
			next_istat[1] = 1'b1;
		end
		// A change of low-power-run enable is reported once status two has followed it.
		if (lp_run_d != ctrl1[LPRUN_EN_BIT]) begin
			next_istat[2] = 1'b1;
		end
	end

	// One register stage for all state; the synchronous reset also clears low-power-run enable.
	always_ff @(posedge clk_in) begin
		if (srst_in) begin
			ctrl1  <= CTRL1_RST;
			ctrl2  <= CTRL2_RST;
			ctrl3  <= CTRL3_RST;
			stby_flag <= 1'b0;
			iwkf   <= 1'b0;
			imask  <= IMASK_RST;
			istat  <= '0;
			rtc_src <= 2'h0;
			mode   <= PM_RUN;
			aw_h   <= 1'b0;
			w_h    <= 1'b0;
			awa    <= 8'h00;
			wd     <= 32'h0;
			ws     <= 4'h0;
			bv     <= 1'b0;
			br     <= BRESP_OK;
			rv     <= 1'b0;
			rd     <= 32'h0;
			lp_run_d <= 1'b0;
		end else begin
			ctrl1  <= next_ctrl1;
			ctrl2  <= next_ctrl2;
			ctrl3  <= next_ctrl3;
			stby_flag <= next_stby_flag;
			iwkf   <= next_iwkf;
			imask  <= next_imask;
			istat  <= next_istat;
			rtc_src <= next_rtc_src;
			mode   <= next_mode;
			aw_h   <= next_aw_h;
			w_h    <= next_w_h;
			awa    <= next_awa;
			wd     <= next_wd;
			ws     <= next_ws;
			bv     <= next_bv;
			br     <= next_br;
			rv     <= next_rv;
			rd     <= next_rd;
			lp_run_d <= next_lp_run_d;
		end
	end

	// Steering follows the control register directly, so the two regulators never overlap.
	assign main_regulator_on_out      = ~ctrl1[LPRUN_EN_BIT];
	assign low_power_regulator_on_out = ctrl1[LPRUN_EN_BIT];
	assign main_regulator_level_out   = ctrl1[MRL_HI:MRL_LO];
	assign level_1v0_out              = ctrl1[MRL_HI:MRL_LO] == MRL_1V0;
	assign level_1v1_out              = ctrl1[MRL_HI:MRL_LO] == MRL_1V1;
	assign backup_write_enable_out    = ctrl1[UNLK_BIT];
	assign rtc_source_select_out      = rtc_src;
	assign stop2_out                  = mode == PM_STOP2;
	assign standby_out                = mode == PM_STBY;
	assign irq_out                    = |(istat & imask);
endmodule : power_mode_control_autowake

/* File: bench/pwr_mode_monitor.sv */
// Checker for the power-mode control block: bus answers and steering outputs.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ps
module pwr_mode_monitor
	import pwr_ctrl_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic s_axi_awvalid_in,
	input wire logic s_axi_awready_out,
	input wire logic s_axi_wvalid_in,
	input wire logic s_axi_wready_out,
	input wire logic s_axi_bvalid_out,
	input wire logic s_axi_arvalid_in,
	input wire logic s_axi_arready_out,
	input wire logic s_axi_rvalid_out,
	input wire logic main_regulator_on_out,
	input wire logic low_power_regulator_on_out,
	input wire logic [1:0] main_regulator_level_out,
	input wire logic level_1v0_out,
	input wire logic level_1v1_out,
	input wire logic backup_write_enable_out,
	input wire logic line18_wake_in,
	input wire logic stop2_out,
	input wire logic standby_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (srst_in);
	sequence wr_taken;
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out;
	endsequence
	sequence rd_taken;
		s_axi_arvalid_in && s_axi_arready_out;
	endsequence
	a_write_answer: assert property (wr_taken |-> ##[1:2] s_axi_bvalid_out)
		else $error("write answer missing");
	a_read_answer: assert property (rd_taken |=> s_axi_rvalid_out)
		else $error("read answer missing");
	a_read_ready: assert property (s_axi_arready_out == !s_axi_rvalid_out)
		else $error("read ready wrong");
	a_reg_swap: assert property (main_regulator_on_out != low_power_regulator_on_out)
		else $error("regulators not exclusive");
	a_level_decode: assert property (level_1v0_out == (main_regulator_level_out == MRL_1V0)
		&& level_1v1_out == (main_regulator_level_out == MRL_1V1))
		else $error("level decode wrong");
	a_reset_values: assert property ($fell(srst_in) |-> main_regulator_on_out
		&& backup_write_enable_out && main_regulator_level_out == MRL_1V1)
		else $error("reset values wrong");
	a_modes_excl: assert property (!(stop2_out && standby_out))
		else $error("two sleep modes at once");
	a_standby_exit: assert property ($fell(standby_out) |-> ##[0:2]
		(backup_write_enable_out && main_regulator_on_out))
		else $error("standby exit did not reload");
	a_stop2_wake: assert property (stop2_out && line18_wake_in |-> ##[1:3] !stop2_out)
		else $error("stop2 wake missing");
endmodule : pwr_mode_monitor
bind power_mode_control_autowake pwr_mode_monitor mon (.*);

/* File: bench/power_mode_control_autowake_tb.sv */
// Self-checking bench for the power-mode control block over AXI4-Lite.
// Assumes the package, design and checker are compiled first.
`timescale 1ns/1ps
module power_mode_control_autowake_tb import pwr_ctrl_pkg::*;;
	logic clk_in, srst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in;
	logic s_axi_arvalid_in, s_axi_rready_in, deep_sleep_req_in, sleep_req_in;
	logic rtc_alarm_in, line18_wake_in, pvd_out_in, s_axi_awready_out, s_axi_wready_out;
	logic s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out, main_regulator_on_out;
	logic low_power_regulator_on_out, level_1v0_out, level_1v1_out, backup_write_enable_out;
	logic stop2_out, standby_out, irq_out, lp;
	logic [7:0] s_axi_awaddr_in, s_axi_araddr_in;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out, seed, m1;
	logic [3:0] s_axi_wstrb_in;
	logic [2:0] ev;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out, main_regulator_level_out, rtc_source_select_out;
	int err_total = 0, check_count = 0, cyc = 0;
	power_mode_control_autowake uut (.*);
	initial begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	task automatic chk(input string n, input logic [31:0] s, e);
		check_count++;
		if (s !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic close_out();
		if (err_total == 0 && check_count > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : close_out
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r = BRESP_OK);
		@(posedge clk_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= v;
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		s_axi_bready_in <= 1'b1;
		do begin
			@(posedge clk_in);
			if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
			if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
		end while (!s_axi_bvalid_out);
		s_axi_bready_in <= 1'b0;
		chk("bresp", 32'(s_axi_bresp_out), 32'(r));
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e, m = 32'hffff_ffff);
		@(posedge clk_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		s_axi_rready_in <= 1'b1;
		do begin
			@(posedge clk_in);
			if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
		end while (!s_axi_rvalid_out);
		s_axi_rready_in <= 1'b0;
		chk($sformatf("read %h", a), s_axi_rdata_out & m, e);
		chk("rresp", 32'(s_axi_rresp_out), 32'(BRESP_OK));
	endtask : rd
	task automatic wt(ref logic s, input logic v);
		for (int k = 0; k < 20 && s !== v; k++) @(posedge clk_in);
	endtask : wt
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc > 5000) begin
			err_total++;
			close_out();
		end
	end
	initial begin
		{srst_in, s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in} = 4'h8;
		{s_axi_arvalid_in, s_axi_rready_in, deep_sleep_req_in, sleep_req_in} = 4'h0;
		{rtc_alarm_in, line18_wake_in, pvd_out_in} = 3'h1;
		{s_axi_awaddr_in, s_axi_araddr_in, s_axi_wdata_in} = 48'h0;
		s_axi_wstrb_in = 4'hf;
		seed = 32'h0000_8e39;
		ev = 3'h0;
		lp = 1'b0;
		repeat (5) @(posedge clk_in);
		srst_in <= 1'b0;
		rd(OFS_CTRL1, CTRL1_RST);
		rd(OFS_CTRL2, CTRL2_RST);
		rd(OFS_CTRL3, CTRL3_RST);
		rd(OFS_CLR, 32'h0);
		rd(OFS_STS2, 32'h6);
		repeat (4) begin
			m1 = xs();
			wr(OFS_CTRL1, m1);
			m1 &= CTRL1_WM;
			ev[2] |= m1[14] ^ lp;
			lp = m1[14];
			rd(OFS_CTRL1, m1);
			chk("main_on", 32'(main_regulator_on_out), 32'(!m1[14]));
			chk("lp_on", 32'(low_power_regulator_on_out), 32'(m1[14]));
			chk("level", 32'({level_1v1_out, level_1v0_out, main_regulator_level_out}),
				32'({m1[10:9] == MRL_1V1, m1[10:9] == MRL_1V0, m1[10:9]}));
			chk("unlock", 32'(backup_write_enable_out), 32'(m1[8]));
		end
		ev[2] |= lp;
		wr(OFS_CTRL1, 32'h0);
		wr(OFS_RTCS, 32'h3);
		rd(OFS_RTCS, 32'h0);
		wr(OFS_CTRL1, 32'h100);
		wr(OFS_RTCS, 32'h2);
		rd(OFS_RTCS, 32'h2);
		chk("rtcsel", 32'(rtc_source_select_out), 32'h2);
		wr(8'h40, xs(), BRESP_ERR);
		rd(8'h40, 32'h0);
		rd(OFS_ISTAT, 32'(ev));
		wr(OFS_CTRL3, CTRL3_RST | 32'h4000);
		for (int s = 0; s < 4; s++) begin
			wr(OFS_CTRL1, 32'(s));
			deep_sleep_req_in <= 1'b1;
			@(posedge clk_in);
			deep_sleep_req_in <= 1'b0;
			if (s < 3) wt(stop2_out, 1'b1);
			else wt(standby_out, 1'b1);
			chk("mode", 32'({stop2_out, standby_out}), 32'({s < 3, s == 3}));
			if (s < 3) begin
				line18_wake_in <= 1'b1;
				wt(stop2_out, 1'b0);
				line18_wake_in <= 1'b0;
			end else begin
				rtc_alarm_in <= 1'b1;
				wt(standby_out, 1'b0);
				rtc_alarm_in <= 1'b0;
			end
			chk("awake", 32'({stop2_out, standby_out}), 32'h0);
		end
		rd(OFS_CTRL1, CTRL1_RST);
		rd(OFS_CTRL3, CTRL3_RST);
		rd(OFS_STS1, 32'h100, 32'h100);
		wr(OFS_IMASK, 32'h1);
		wt(irq_out, 1'b1);
		chk("irq", 32'(irq_out), 32'h1);
		rd(OFS_ISTAT, 32'h3);
		wt(irq_out, 1'b0);
		chk("irq", 32'(irq_out), 32'h0);
		wr(OFS_CLR, 32'h0);
		rd(OFS_STS1, 32'h100, 32'h100);
		wr(OFS_CLR, 32'h8100);
		rd(OFS_STS1, 32'h0);
		pvd_out_in <= 1'b0;
		rd(OFS_STS2, 32'h2);
		wr(OFS_CTRL1, 32'h4000);
		srst_in <= 1'b1;
		repeat (5) @(posedge clk_in);
		srst_in <= 1'b0;
		rd(OFS_CTRL1, CTRL1_RST);
		close_out();
	end
endmodule : power_mode_control_autowake_tb
